// ---- hdl/intc_pkg.sv ----
// intc_pkg: register map, field layout and shared types of the interrupt controller
// assumes an APB slave with 32-bit data, one byte-wide register per aligned word
package intc_pkg;
   localparam int ADDR_W = 16;
   localparam int REG_W = 8;
   localparam logic [1:0] LEVEL_NONE = 2'h0;
   localparam logic [2:0] LEVEL_NMI = 3'h4;
   // printed offsets are not multiples of four: they are indices, byte address = index * 4
   localparam logic [15:0] IDX_PRIO_CSK = 16'hFF20;
   localparam logic [15:0] IDX_PRIO_T03 = 16'hFF21;
   localparam logic [15:0] IDX_EN_TICK = 16'hFF22;
   localparam logic [15:0] IDX_EN_SER = 16'hFF23;
   localparam logic [15:0] IDX_EN_KEY = 16'hFF24;
   localparam logic [15:0] IDX_EN_T03 = 16'hFF25;
   localparam logic [15:0] IDX_PEND_TICK = 16'hFF26;
   localparam logic [15:0] IDX_PEND_SER = 16'hFF27;
   localparam logic [15:0] IDX_PEND_KEY = 16'hFF28;
   localparam logic [15:0] IDX_PEND_T03 = 16'hFF29;
   localparam logic [15:0] IDX_PRIO_T47 = 16'hFF2A;
   localparam logic [15:0] IDX_EN_T47 = 16'hFF2C;
   localparam logic [15:0] IDX_PEND_T47 = 16'hFF2E;
   // own registers: key edge select and cpu mask view
   localparam logic [15:0] IDX_KEY_EDGE = 16'hFF30;
   localparam logic [15:0] IDX_CPU_MASK = 16'hFF31;
   localparam logic [7:0] MASK_TICK = 8'h0F;
   localparam logic [7:0] MASK_SER = 8'h07;
   localparam logic [7:0] MASK_PRIO_CSK = 8'hF3;
   localparam logic [7:0] MASK_PRIO_T = 8'h3C;
   localparam logic [7:0] MASK_PRIO_T47 = 8'h0F;
   localparam logic [7:0] RESET_VAL = 8'h00;
   // priority field positions
   localparam int POS_TICK_LVL = 0;
   localparam int POS_SER_LVL = 4;
   localparam int POS_KEY_LVL = 6;
   localparam int POS_T01_LVL = 2;
   localparam int POS_T23_LVL = 4;
   localparam int POS_T45_LVL = 0;
   localparam int POS_T67_LVL = 2;
   localparam int NUM_GROUPS = 7;
   localparam int STACK_DEPTH = 4;

   typedef struct packed {
      logic [7:0] key;
      logic [7:0] t03;
      logic [7:0] t47;
      logic [2:0] ser;
      logic [3:0] tick;
   } src_vec_s;

   // cpu handshake toward the core
   typedef struct packed {
      logic accept;
      logic nmi;
      logic ret;
   } cpu_evt_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01
   } apb_st_e;
endpackage : intc_pkg

// ---- hdl/prio_intc.sv ----
// prio_intc: pending flags, enables, group levels and cpu mask nesting
// assumes sources are pins from outside pclk (synchronised here) and an APB master
`timescale 1ns/1ps
module prio_intc #(
   parameter int KEYS = 8
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event sources, asynchronous to pclk
   input wire logic [KEYS-1:0] key_in,
   input wire logic [7:0] timer_underflow,
   input wire logic [7:0] timer_match,
   input wire logic [2:0] serial_event,
   input wire logic [3:0] tick_in,
   input wire logic watchdog_nmi,
   // cpu core
   input wire logic opcode_fetch,
   input wire logic return_from_exception,
   output logic [2:0] cpu_level_req,
   output logic [5:0] vector_addr,
   output logic accept_pulse,
   output logic [1:0] cpu_mask
);
   localparam int NSRC = 31;
   // top bit carries the last key pin, so every pin shares one synchroniser
   logic [NSRC:0] raw_async, s1_ff, s2_ff, s3_ff;
   logic [KEYS-1:0] key_edge_ff, nxt_key_edge;
   logic [7:0] pend_key_ff, pend_t03_ff, pend_t47_ff, en_key_ff, en_t03_ff, en_t47_ff;
   logic [2:0] pend_ser_ff, en_ser_ff;
   logic [3:0] pend_tick_ff, en_tick_ff;
   logic [7:0] prio_csk_ff, prio_t03_ff, prio_t47_ff;
   logic [7:0] nxt_pend_key, nxt_pend_t03, nxt_pend_t47, nxt_en_key, nxt_en_t03, nxt_en_t47;
   logic [2:0] nxt_pend_ser, nxt_en_ser;
   logic [3:0] nxt_pend_tick, nxt_en_tick;
   logic [7:0] nxt_prio_csk, nxt_prio_t03, nxt_prio_t47;
   logic [NSRC-1:0] evt;
   intc_pkg::apb_st_e st_ff, nxt_st;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic [1:0] mask_ff, nxt_mask;
   logic [1:0] stack_ff [intc_pkg::STACK_DEPTH];
   logic [1:0] nxt_stack [intc_pkg::STACK_DEPTH];
   logic [2:0] sp_ff, nxt_sp;
   logic [2:0] lvl_ff, nxt_lvl;
   logic [5:0] vec_ff, nxt_vec;
   logic acc_ff, nxt_acc;
   logic nmi_prev_ff;

   assign raw_async = {key_in[KEYS-1], watchdog_nmi, tick_in, serial_event,
                       timer_match[7:4], timer_underflow[7:4], timer_match[3:0],
                       timer_underflow[3:0], key_in[KEYS-2:0]};

   // all sources two-flop synchronised; the third stage only feeds edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= raw_async;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   logic [KEYS-1:0] key_now, key_old, ev_key;
   assign key_now = {s2_ff[NSRC], s2_ff[KEYS-2:0]};
   assign key_old = {s3_ff[NSRC], s3_ff[KEYS-2:0]};

   // event detection: keys per edge select, timer/serial rising, ticks falling
   always_comb begin
      evt = '0;
      ev_key = '0;
      for (int i = 0; i < KEYS; i++) begin
         ev_key[i] = key_edge_ff[i] ? (key_now[i] & ~key_old[i])
                                    : (~key_now[i] & key_old[i]);
      end
      for (int i = 7; i < 26; i++) begin
         evt[i] = s2_ff[i] & ~s3_ff[i];
      end
      for (int i = 26; i < 30; i++) begin
         evt[i] = ~s2_ff[i] & s3_ff[i];
      end
   end

   logic [7:0] ev_t03, ev_t47;
   logic [2:0] ev_ser;
   logic [3:0] ev_tick;
   // underflow at even bit, match at odd bit
   assign ev_t03 = {evt[14], evt[10], evt[13], evt[9], evt[12], evt[8], evt[11], evt[7]};
   assign ev_t47 = {evt[22], evt[18], evt[21], evt[17], evt[20], evt[16], evt[19], evt[15]};
   assign ev_ser = evt[25:23];
   assign ev_tick = evt[29:26];

   function automatic logic [15:0] reg_index(input logic [31:0] a);
      reg_index = a[17:2];
   endfunction : reg_index

   function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] ev,
                                      input logic hit, input logic [7:0] wd);
      // set beats clear in the same cycle
      w1c = (cur & ~(hit ? wd : 8'h00)) | ev;
   endfunction : w1c

   logic wr_en, rd_en;
   logic [15:0] idx;
   logic [7:0] wd;
   assign idx = reg_index(paddr);
   assign wd = pwdata[7:0];
   assign wr_en = psel & penable & pwrite & (st_ff == intc_pkg::ST_WAIT);
   assign rd_en = psel & penable & ~pwrite & (st_ff == intc_pkg::ST_WAIT);

   logic mapped;
   always_comb begin
      mapped = 1'b1;
      case (idx)
         intc_pkg::IDX_PRIO_CSK: nxt_prdata = {24'h0, prio_csk_ff};
         intc_pkg::IDX_PRIO_T03: nxt_prdata = {24'h0, prio_t03_ff};
         intc_pkg::IDX_PRIO_T47: nxt_prdata = {24'h0, prio_t47_ff};
         intc_pkg::IDX_EN_TICK: nxt_prdata = {28'h0, en_tick_ff};
         intc_pkg::IDX_EN_SER: nxt_prdata = {29'h0, en_ser_ff};
         intc_pkg::IDX_EN_KEY: nxt_prdata = {24'h0, en_key_ff};
         intc_pkg::IDX_EN_T03: nxt_prdata = {24'h0, en_t03_ff};
         intc_pkg::IDX_EN_T47: nxt_prdata = {24'h0, en_t47_ff};
         intc_pkg::IDX_PEND_TICK: nxt_prdata = {28'h0, pend_tick_ff};
         intc_pkg::IDX_PEND_SER: nxt_prdata = {29'h0, pend_ser_ff};
         intc_pkg::IDX_PEND_KEY: nxt_prdata = {24'h0, pend_key_ff};
         intc_pkg::IDX_PEND_T03: nxt_prdata = {24'h0, pend_t03_ff};
         intc_pkg::IDX_PEND_T47: nxt_prdata = {24'h0, pend_t47_ff};
         intc_pkg::IDX_KEY_EDGE: nxt_prdata = {24'h0, key_edge_ff};
         intc_pkg::IDX_CPU_MASK: nxt_prdata = {30'h0, mask_ff};
         default: begin
            nxt_prdata = 32'h0;
            mapped = 1'b0;
         end
      endcase
      if (!rd_en) begin
         nxt_prdata = prdata_ff;
      end
   end

   // one wait state: setup, then access answered on the following edge
   always_comb begin
      nxt_st = st_ff;
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      case (st_ff)
         intc_pkg::ST_IDLE: begin
            if (psel && !penable) begin
               nxt_st = intc_pkg::ST_WAIT;
            end
         end
         intc_pkg::ST_WAIT: begin
            if (psel && penable && !pready_ff) begin
               nxt_pready = 1'b1;
               nxt_pslverr = ~mapped;
            end else begin
               nxt_st = intc_pkg::ST_IDLE;
            end
         end
         default: nxt_st = intc_pkg::ST_IDLE;
      endcase
   end

   logic wr_fire;
   // a write lands on the completing edge, where the master sees pready high
   assign wr_fire = wr_en & pready_ff;

   always_comb begin
      nxt_en_key = en_key_ff;
      nxt_en_t03 = en_t03_ff;
      nxt_en_t47 = en_t47_ff;
      nxt_en_ser = en_ser_ff;
      nxt_en_tick = en_tick_ff;
      nxt_prio_csk = prio_csk_ff;
      nxt_prio_t03 = prio_t03_ff;
      nxt_prio_t47 = prio_t47_ff;
      nxt_key_edge = key_edge_ff;
      if (wr_fire) begin
         case (idx)
            intc_pkg::IDX_EN_KEY: nxt_en_key = wd;
            intc_pkg::IDX_EN_T03: nxt_en_t03 = wd;
            intc_pkg::IDX_EN_T47: nxt_en_t47 = wd;
            intc_pkg::IDX_EN_SER: nxt_en_ser = wd[2:0];
            intc_pkg::IDX_EN_TICK: nxt_en_tick = wd[3:0];
            intc_pkg::IDX_PRIO_CSK: nxt_prio_csk = wd & intc_pkg::MASK_PRIO_CSK;
            intc_pkg::IDX_PRIO_T03: nxt_prio_t03 = wd & intc_pkg::MASK_PRIO_T;
            intc_pkg::IDX_PRIO_T47: nxt_prio_t47 = wd & intc_pkg::MASK_PRIO_T47;
            intc_pkg::IDX_KEY_EDGE: nxt_key_edge = wd[KEYS-1:0];
            default: ;
         endcase
      end
      nxt_pend_key = w1c(pend_key_ff, ev_key, wr_fire && idx == intc_pkg::IDX_PEND_KEY, wd);
      nxt_pend_t03 = w1c(pend_t03_ff, ev_t03, wr_fire && idx == intc_pkg::IDX_PEND_T03, wd);
      nxt_pend_t47 = w1c(pend_t47_ff, ev_t47, wr_fire && idx == intc_pkg::IDX_PEND_T47, wd);
      nxt_pend_ser = 3'(w1c({5'h0, pend_ser_ff}, {5'h0, ev_ser},
                            wr_fire && idx == intc_pkg::IDX_PEND_SER, wd));
      nxt_pend_tick = 4'(w1c({4'h0, pend_tick_ff}, {4'h0, ev_tick},
                             wr_fire && idx == intc_pkg::IDX_PEND_TICK, wd));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= intc_pkg::ST_IDLE;
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         pend_key_ff <= intc_pkg::RESET_VAL;
         pend_t03_ff <= intc_pkg::RESET_VAL;
         pend_t47_ff <= intc_pkg::RESET_VAL;
         pend_ser_ff <= 3'h0;
         pend_tick_ff <= 4'h0;
         en_key_ff <= intc_pkg::RESET_VAL;
         en_t03_ff <= intc_pkg::RESET_VAL;
         en_t47_ff <= intc_pkg::RESET_VAL;
         en_ser_ff <= 3'h0;
         en_tick_ff <= 4'h0;
         prio_csk_ff <= intc_pkg::RESET_VAL;
         prio_t03_ff <= intc_pkg::RESET_VAL;
         prio_t47_ff <= intc_pkg::RESET_VAL;
         key_edge_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         pend_key_ff <= nxt_pend_key;
         pend_t03_ff <= nxt_pend_t03;
         pend_t47_ff <= nxt_pend_t47;
         pend_ser_ff <= nxt_pend_ser;
         pend_tick_ff <= nxt_pend_tick;
         en_key_ff <= nxt_en_key;
         en_t03_ff <= nxt_en_t03;
         en_t47_ff <= nxt_en_t47;
         en_ser_ff <= nxt_en_ser;
         en_tick_ff <= nxt_en_tick;
         prio_csk_ff <= nxt_prio_csk;
         prio_t03_ff <= nxt_prio_t03;
         prio_t47_ff <= nxt_prio_t47;
         key_edge_ff <= nxt_key_edge;
      end
   end

   // active sources in fixed vector order: keys 7..0, timers 0-3, serial, ticks, timers 4-7
   logic [NSRC-1:0] act;
   logic [1:0] lvl_of [NSRC];
   assign act = {pend_t47_ff & en_t47_ff, pend_tick_ff & en_tick_ff,
                 pend_ser_ff & en_ser_ff, pend_t03_ff & en_t03_ff,
                 pend_key_ff & en_key_ff};

   // vector slot (word index) of each source; reserved slots skipped
   function automatic logic [5:0] slot_of(input int s);
      if (s < 8) slot_of = 6'(3 + 7 - s);
      else if (s < 16) slot_of = 6'(11 + s - 8);
      else if (s < 19) slot_of = 6'(20 + 18 - s);
      else if (s < 23) slot_of = 6'(26 + 22 - s);
      else slot_of = 6'(30 + s - 23);
   endfunction : slot_of

   for (genvar s = 0; s < NSRC; s++) begin : g_lvl
      if (s < 8) begin : g_k
         assign lvl_of[s] = prio_csk_ff[intc_pkg::POS_KEY_LVL +: 2];
      end else if (s < 12) begin : g_a
         assign lvl_of[s] = prio_t03_ff[intc_pkg::POS_T01_LVL +: 2];
      end else if (s < 16) begin : g_b
         assign lvl_of[s] = prio_t03_ff[intc_pkg::POS_T23_LVL +: 2];
      end else if (s < 19) begin : g_s
         assign lvl_of[s] = prio_csk_ff[intc_pkg::POS_SER_LVL +: 2];
      end else if (s < 23) begin : g_t
         assign lvl_of[s] = prio_csk_ff[intc_pkg::POS_TICK_LVL +: 2];
      end else if (s < 27) begin : g_c
         assign lvl_of[s] = prio_t47_ff[intc_pkg::POS_T45_LVL +: 2];
      end else begin : g_d
         assign lvl_of[s] = prio_t47_ff[intc_pkg::POS_T67_LVL +: 2];
      end
   end

   // highest level wins; within a level the lowest vector slot wins
   logic [1:0] best_lvl;
   logic [5:0] best_slot;
   always_comb begin
      best_lvl = intc_pkg::LEVEL_NONE;
      best_slot = 6'h3F;
      for (int s = 0; s < NSRC; s++) begin
         if (act[s] && lvl_of[s] != intc_pkg::LEVEL_NONE) begin
            if (lvl_of[s] > best_lvl ||
                (lvl_of[s] == best_lvl && slot_of(s) < best_slot)) begin
               best_lvl = lvl_of[s];
               best_slot = slot_of(s);
            end
         end
      end
   end

   logic nmi_edge;
   assign nmi_edge = s2_ff[NSRC-1] & ~nmi_prev_ff;
   logic nmi_hold_ff, nxt_nmi_hold;

   // acceptance sampled at opcode fetch; nmi ignores mask, others need level > mask
   always_comb begin
      nxt_mask = mask_ff;
      nxt_sp = sp_ff;
      nxt_stack = stack_ff;
      nxt_acc = 1'b0;
      nxt_vec = vec_ff;
      nxt_nmi_hold = nmi_hold_ff | nmi_edge;
      nxt_lvl = nmi_hold_ff ? intc_pkg::LEVEL_NMI : {1'b0, best_lvl};
      if (opcode_fetch && nmi_hold_ff) begin
         nxt_acc = 1'b1;
         nxt_nmi_hold = nmi_edge;
         nxt_mask = 2'h3;
         nxt_vec = 6'h2;
         nxt_stack[sp_ff[1:0]] = mask_ff;
         nxt_sp = sp_ff + 3'h1;
      end else if (opcode_fetch && best_lvl > mask_ff) begin
         nxt_acc = 1'b1;
         nxt_mask = best_lvl;
         nxt_vec = best_slot;
         nxt_stack[sp_ff[1:0]] = mask_ff;
         nxt_sp = sp_ff + 3'h1;
      end else if (return_from_exception && sp_ff != 3'h0) begin
         nxt_mask = stack_ff[2'(sp_ff - 3'h1)];
         nxt_sp = sp_ff - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= 2'h0;
         sp_ff <= 3'h0;
         stack_ff <= '{default: 2'h0};
         acc_ff <= 1'b0;
         vec_ff <= 6'h0;
         lvl_ff <= 3'h0;
         nmi_prev_ff <= 1'b0;
         nmi_hold_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         sp_ff <= nxt_sp;
         stack_ff <= nxt_stack;
         acc_ff <= nxt_acc;
         vec_ff <= nxt_vec;
         lvl_ff <= nxt_lvl;
         nmi_prev_ff <= s2_ff[NSRC-1];
         nmi_hold_ff <= nxt_nmi_hold;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign cpu_level_req = lvl_ff;
   assign vector_addr = vec_ff;
   assign accept_pulse = acc_ff;
   assign cpu_mask = mask_ff;

   a_clear_w1c: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fire && idx == intc_pkg::IDX_PEND_KEY && wd[0] && !ev_key[0]) |=> !pend_key_ff[0])
      else $error("key pending bit not cleared");
   a_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_t03 != 8'h00) |=> ((pend_t03_ff & $past(ev_t03)) == $past(ev_t03)))
      else $error("timer event lost");
   a_accept_mask: assert property (@(posedge pclk) disable iff (!presetn)
      (opcode_fetch && !nmi_hold_ff && best_lvl > mask_ff) |=> (mask_ff == $past(best_lvl)))
      else $error("mask not loaded with level");
   a_masked_none: assert property (@(posedge pclk) disable iff (!presetn)
      (opcode_fetch && !nmi_hold_ff && best_lvl <= mask_ff) |=> !accept_pulse)
      else $error("masked request accepted");
   a_nmi_always: assert property (@(posedge pclk) disable iff (!presetn)
      (opcode_fetch && nmi_hold_ff) |=> (accept_pulse && cpu_mask == 2'h3))
      else $error("nmi not accepted");
   a_ret_restore: assert property (@(posedge pclk) disable iff (!presetn)
      (return_from_exception && sp_ff != 3'h0 &&
       !(opcode_fetch && (nmi_hold_ff || best_lvl > mask_ff)))
      |=> (sp_ff == $past(sp_ff) - 3'h1 && mask_ff <= $past(mask_ff)))
      else $error("mask not restored");
   a_level_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (prio_csk_ff == 8'h0 && prio_t03_ff == 8'h0 && prio_t47_ff == 8'h0 && !nmi_hold_ff)
      |=> cpu_level_req == 3'h0)
      else $error("level 0 group requested");
   a_hold_req: assert property (@(posedge pclk) disable iff (!presetn)
      (pend_key_ff[0] && en_key_ff[0] && prio_csk_ff[intc_pkg::POS_KEY_LVL +: 2] == 2'h2)
      |=> cpu_level_req >= 3'h2)
      else $error("request dropped while pending");
endmodule : prio_intc

// ---- verif/cpu_model.sv ----
// cpu_model: behavioural core side, issues opcode fetches and handler returns
// assumes the bench raises run to let fetches flow and pulses ret_req for one cycle
`timescale 1ns/1ps
module cpu_model #(
   parameter int FETCH_GAP = 5
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control
   input wire logic run,
   input wire logic ret_req,
   // toward the controller
   output logic opcode_fetch,
   output logic return_from_exception
);
   logic [3:0] gap_ff;

   // fetches are one cycle wide; the gap stands for instruction length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff <= 4'h0;
         opcode_fetch <= 1'b0;
         return_from_exception <= 1'b0;
      end else begin
         opcode_fetch <= run && gap_ff == 4'h0;
         gap_ff <= (gap_ff == 4'h0) ? 4'(FETCH_GAP) : gap_ff - 4'h1;
         return_from_exception <= ret_req;
      end
   end
endmodule : cpu_model

// ---- verif/tb_top.sv ----
// tb_top: self-checking bench for the prioritised interrupt controller
// assumes pready within 20 cycles and cpu_model on the core side
`timescale 1ns/1ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] key_in = 8'h00;
   logic [7:0] timer_underflow = 8'h00;
   logic [7:0] timer_match = 8'h00;
   logic [2:0] serial_event = 3'h0;
   logic [3:0] tick_in = 4'h0;
   logic watchdog_nmi = 1'b0;
   logic run = 1'b0;
   logic ret_req = 1'b0;
   logic opcode_fetch;
   logic return_from_exception;
   logic [2:0] cpu_level_req;
   logic [5:0] vector_addr;
   logic accept_pulse;
   logic [1:0] cpu_mask;
   logic [31:0] rd;
   logic er;
   int n_fail = 0;
   int comparisons = 0;
   int n_acc = 0;
   int b;

   prio_intc #(.KEYS(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_in(key_in),
      .timer_underflow(timer_underflow), .timer_match(timer_match),
      .serial_event(serial_event), .tick_in(tick_in), .watchdog_nmi(watchdog_nmi),
      .opcode_fetch(opcode_fetch), .return_from_exception(return_from_exception),
      .cpu_level_req(cpu_level_req), .vector_addr(vector_addr),
      .accept_pulse(accept_pulse), .cpu_mask(cpu_mask));
   cpu_model #(.FETCH_GAP(5)) core (.pclk(pclk), .presetn(presetn), .run(run),
      .ret_req(ret_req), .opcode_fetch(opcode_fetch),
      .return_from_exception(return_from_exception));

   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (accept_pulse === 1'b1) n_acc++;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      chk("pready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rc(input logic [15:0] i, input logic [7:0] e);
      apb(1'b0, i, 8'h00);
      chk($sformatf("reg %h", i), {24'h0, e}, rd);
   endtask : rc

   task automatic ret;
      ret_req <= 1'b1;
      @(posedge pclk);
      ret_req <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : ret

   // counting accepts avoids missing a pulse that lands before the wait starts
   task automatic wait_acc(input int base, input logic [1:0] m, input logic [5:0] s);
      int n;
      n = 0;
      while (n_acc == base && n < 200) begin
         @(posedge pclk);
         n++;
      end
      repeat (2) @(posedge pclk);
      chk("accept", 32'h1, {31'h0, n_acc > base});
      chk("cpu_mask", {30'h0, m}, {30'h0, cpu_mask});
      chk("vector_addr", {26'h0, s}, {26'h0, vector_addr});
   endtask : wait_acc

   task automatic s_regs;
      logic [15:0] ix [13];
      logic [15:0] rw [8];
      logic [7:0] mk [8];
      ix = '{16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23, 16'hFF24, 16'hFF25, 16'hFF26,
         16'hFF27, 16'hFF28, 16'hFF29, 16'hFF2A, 16'hFF2C, 16'hFF2E};
      rw = '{16'hFF20, 16'hFF21, 16'hFF2A, 16'hFF22, 16'hFF23, 16'hFF24, 16'hFF25, 16'hFF2C};
      mk = '{8'hF3, 8'h3C, 8'h0F, 8'h0F, 8'h07, 8'hFF, 8'hFF, 8'hFF};
      foreach (ix[k]) rc(ix[k], 8'h00);
      foreach (rw[k]) begin
         apb(1'b1, rw[k], 8'hFF);
         rc(rw[k], mk[k]);
         apb(1'b1, rw[k], 8'h00);
      end
      apb(1'b0, 16'hFF2B, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
   endtask : s_regs

   logic [15:0] ix_clr [4] = '{16'hFF26, 16'hFF27, 16'hFF29, 16'hFF2E};

   task automatic s_events;
      apb(1'b1, 16'hFF30, 8'h01);
      timer_underflow <= 8'h02;
      timer_match <= 8'h40;
      serial_event <= 3'h4;
      tick_in <= 4'h8;
      key_in <= 8'h03;
      repeat (6) @(posedge pclk);
      rc(16'hFF26, 8'h00);
      rc(16'hFF28, 8'h01);
      timer_underflow <= 8'h00;
      timer_match <= 8'h00;
      serial_event <= 3'h0;
      tick_in <= 4'h0;
      key_in <= 8'h00;
      repeat (6) @(posedge pclk);
      rc(16'hFF29, 8'h04);
      rc(16'hFF2E, 8'h20);
      rc(16'hFF27, 8'h04);
      rc(16'hFF26, 8'h08);
      rc(16'hFF28, 8'h03);
      apb(1'b1, 16'hFF28, 8'h02);
      rc(16'hFF28, 8'h01);
      apb(1'b1, 16'hFF27, 8'h00);
      rc(16'hFF27, 8'h04);
      foreach (ix_clr[k]) apb(1'b1, ix_clr[k], 8'hFF);
   endtask : s_events

   task automatic s_nest;
      apb(1'b1, 16'hFF24, 8'h01);
      repeat (3) @(posedge pclk);
      chk("level off", 32'h0, {29'h0, cpu_level_req});
      apb(1'b1, 16'hFF20, 8'h80);
      repeat (3) @(posedge pclk);
      chk("level key", 32'h2, {29'h0, cpu_level_req});
      b = n_acc;
      run <= 1'b1;
      wait_acc(b, 2'b10, 6'h0A);
      rc(16'hFF31, 8'h02);
      b = n_acc;
      repeat (30) @(posedge pclk);
      chk("masked", 32'h0, n_acc - b);
      apb(1'b1, 16'hFF21, 8'h0C);
      apb(1'b1, 16'hFF25, 8'h01);
      b = n_acc;
      timer_underflow <= 8'h01;
      repeat (4) @(posedge pclk);
      timer_underflow <= 8'h00;
      wait_acc(b, 2'b11, 6'h0B);
      b = n_acc;
      watchdog_nmi <= 1'b1;
      repeat (4) @(posedge pclk);
      watchdog_nmi <= 1'b0;
      wait_acc(b, 2'b11, 6'h02);
      ret();
      chk("mask after nmi", 32'h3, {30'h0, cpu_mask});
      apb(1'b1, 16'hFF29, 8'h01);
      ret();
      chk("mask after timer", 32'h2, {30'h0, cpu_mask});
      b = n_acc;
      ret();
      wait_acc(b, 2'b10, 6'h0A);
      apb(1'b1, 16'hFF28, 8'h01);
      ret();
      chk("mask idle", 32'h0, {30'h0, cpu_mask});
      run <= 1'b0;
   endtask : s_nest

   task automatic wrap_up;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_events();
      s_nest();
      wrap_up();
   end

   initial begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      wrap_up();
   end
endmodule : tb_top
